//--- clk_cfg_if.sv
// Purpose: Carries the master clock settings to the rate decoder and its result back
// Assumes: One clock domain
// Notes: Register bank drives settings, decoder drives result

`timescale 1ns/100ps
`default_nettype none

interface clk_cfg_if;
    logic pll_on;                    // Loop enabled
    logic base_rate_sel;             // High: 1.544 family, low: 2.048 family
    logic [1:0] clock_multiple_sel;  // Multiple of base rate
    logic [15:0] mclk_khz;           // Expected master clock, kHz
    logic mclk_direct;               // Master clock used directly

    // Register bank side
    modport bank (output pll_on, output base_rate_sel, output clock_multiple_sel,
                  input mclk_khz, input mclk_direct);
    // Decoder side
    modport dec (input pll_on, input base_rate_sel, input clock_multiple_sel,
                 output mclk_khz, output mclk_direct);
endinterface

`default_nettype wire

//--- liu_cfg_bank.sv
// Purpose: Clock and receive sensitivity configuration bank on an AHB-Lite slave port
// Assumes: Single word transfers, zero wait states, always OKAY
// Notes: Registers sit at four times their index; unmapped reads give zero
//
// Operation
// - Base set: 1.544 times 1,2,4,8 MHz
// - Base clear: 2.048 times 1,2,4,8 MHz
// - Haul bit set selects long haul
// - Haul banks at 07h and 27h
// - Two channels per sensitivity register
// - Sensitivity registers at 08h-0Ah, 28h-29h
// - Turns bit set selects 1:1 ratio
// - Three-bit field sets sensitivity and gain
// - Codes 0-3 loss, 4-6 monitor gain
// - Loop enable bit turns loop on
// - Base bit picks 1.544 or 2.048 family

`timescale 1ns/100ps
`default_nettype none

module liu_cfg_bank (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic [15:0] long_haul_en,
    output logic [11:0] rx_turns_ratio_ch,
    output logic [35:0] rx_sense_level_ch,
    output logic [11:0] rx_monitor_mode,
    output logic [59:0] rx_monitor_gain_db,
    output logic pll_on,
    output logic base_rate_sel,
    output logic [1:0] clock_multiple_sel,
    output logic mclk_direct,
    output logic [15:0] mclk_khz
);

    // Low and high haul select banks
    logic [7:0] haul_select_low_bank;
    logic [7:0] haul_select_high_bank;
    // Sensitivity registers, ch1-2, 3-4, 5-6, 9-10, 11-12
    // Slot five has no address and stays zero; it feeds the two spare channel outputs
    logic [7:0] rx_sense [0:liu_cfg_pkg::SENSE_REGS-1];
    // Clock control register
    logic [7:0] clock_ctrl;
    // Pending write from the address phase
    logic wr_pend;
    logic [5:0] wr_idx;
    // Read data before forwarding
    logic [31:0] next_rdata;
    // Address phase accepted this cycle
    logic accept;
    // Carrier to the rate decoder
    clk_cfg_if clk_cfg ();

    // Map an index to a sensitivity register slot, or -1
    function automatic int sense_slot(input logic [5:0] idx);
        case (idx)
            liu_cfg_pkg::IDX_SENSE_CH1_CH2: sense_slot = 0;
            liu_cfg_pkg::IDX_SENSE_CH3_CH4: sense_slot = 1;
            liu_cfg_pkg::IDX_SENSE_CH5_CH6: sense_slot = 2;
            liu_cfg_pkg::IDX_SENSE_CH9_CH10: sense_slot = 3;
            liu_cfg_pkg::IDX_SENSE_CH11_CH12: sense_slot = 4;
            default: sense_slot = -1;
        endcase
    endfunction

    // Monitor gain for a sensitivity code; zero for the plain loss codes
    function automatic logic [4:0] monitor_gain(input logic [2:0] code);
        case (code)
            liu_cfg_pkg::SENSE_MON_14DB: monitor_gain = liu_cfg_pkg::GAIN_14DB;
            liu_cfg_pkg::SENSE_MON_20DB: monitor_gain = liu_cfg_pkg::GAIN_20DB;
            liu_cfg_pkg::SENSE_MON_26DB: monitor_gain = liu_cfg_pkg::GAIN_26DB;
            default: monitor_gain = liu_cfg_pkg::GAIN_NONE;
        endcase
    endfunction

    // Whether a code selects monitor mode
    function automatic logic is_monitor(input logic [2:0] code);
        is_monitor = (monitor_gain(code) != liu_cfg_pkg::GAIN_NONE);
    endfunction

    // Whether an index names a register that stores written data
    function automatic logic is_stored(input logic [5:0] idx);
        case (idx)
            liu_cfg_pkg::IDX_HAUL_LO,
            liu_cfg_pkg::IDX_HAUL_HI,
            liu_cfg_pkg::IDX_CLOCK_CTRL:
            begin
                is_stored = 1'b1;
            end
            default:
            begin
                // Sensitivity slots store; status and gaps do not
                is_stored = (sense_slot(idx) >= 0);
            end
        endcase
    endfunction

    // Readable value of a register index, before any pending write
    function automatic logic [31:0] reg_value(input logic [5:0] idx, input logic [7:0] hl, input logic [7:0] hh,
                                              input logic [7:0] s0, input logic [7:0] s1, input logic [7:0] s2,
                                              input logic [7:0] s3, input logic [7:0] s4, input logic [7:0] cc,
                                              input logic dir, input logic [15:0] khz);
        case (idx)
            liu_cfg_pkg::IDX_HAUL_LO: reg_value = {24'h000000, hl};
            liu_cfg_pkg::IDX_HAUL_HI: reg_value = {24'h000000, hh};
            liu_cfg_pkg::IDX_SENSE_CH1_CH2: reg_value = {24'h000000, s0};
            liu_cfg_pkg::IDX_SENSE_CH3_CH4: reg_value = {24'h000000, s1};
            liu_cfg_pkg::IDX_SENSE_CH5_CH6: reg_value = {24'h000000, s2};
            liu_cfg_pkg::IDX_SENSE_CH9_CH10: reg_value = {24'h000000, s3};
            liu_cfg_pkg::IDX_SENSE_CH11_CH12: reg_value = {24'h000000, s4};
            liu_cfg_pkg::IDX_CLOCK_CTRL: reg_value = {24'h000000, cc};
            liu_cfg_pkg::IDX_CLOCK_STATUS: reg_value = {15'h0000, dir, khz};
            default: reg_value = 32'h00000000;
        endcase
    endfunction

    // Zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    // A valid transfer is accepted when the clock enable is high, the slave is selected and the bus is ready
    assign accept = ce && hsel && hready && htrans[1];

    // Remember a write address phase for its data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend <= 1'b0;
            wr_idx <= 6'h00;
        end
        else if (ce)
        begin
            // Only accepted writes to storing registers are kept
            // Status and unmapped indices never leave a write pending
            wr_pend <= accept && hwrite && is_stored(haddr[7:2]);
            wr_idx <= haddr[7:2];
        end
    end

    // Haul select banks, reset to zero
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            haul_select_low_bank <= liu_cfg_pkg::REG_RESET;
            haul_select_high_bank <= liu_cfg_pkg::REG_RESET;
        end
        else if (ce && wr_pend)
        begin
            // Bit k holds the bank's lowest channel plus k
            if (wr_idx == liu_cfg_pkg::IDX_HAUL_LO)
            begin
                haul_select_low_bank <= hwdata[7:0];
            end
            if (wr_idx == liu_cfg_pkg::IDX_HAUL_HI)
            begin
                haul_select_high_bank <= hwdata[7:0];
            end
        end
    end

    // Receive sensitivity registers, reset to zero
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            for (int i = 0; i < liu_cfg_pkg::SENSE_REGS; i++)
            begin
                rx_sense[i] <= liu_cfg_pkg::REG_RESET;
            end
        end
        else if (ce && wr_pend)
        begin
            // Only a mapped slot takes the write
            for (int i = 0; i < liu_cfg_pkg::SENSE_REGS; i++)
            begin
                if (sense_slot(wr_idx) == i)
                begin
                    rx_sense[i] <= hwdata[7:0];
                end
            end
        end
    end

    // Clock control register, reset to loop off
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            clock_ctrl <= liu_cfg_pkg::REG_RESET;
        end
        else if (ce && wr_pend && wr_idx == liu_cfg_pkg::IDX_CLOCK_CTRL)
        begin
            // Upper bits are stored but steer nothing
            clock_ctrl <= hwdata[7:0];
        end
    end

    // Read value for the address now on the bus; reading has no side effect
    always_comb
    begin
        next_rdata = reg_value(haddr[7:2], haul_select_low_bank, haul_select_high_bank, rx_sense[0],
                               rx_sense[1], rx_sense[2], rx_sense[3], rx_sense[4], clock_ctrl,
                               clk_cfg.mclk_direct, clk_cfg.mclk_khz);
        // A write landing at this same edge is forwarded so the read sees it
        if (wr_pend && wr_idx == haddr[7:2])
        begin
            // Pending writes only ever name storing registers
            next_rdata = {24'h000000, hwdata[7:0]};
        end
    end

    // Read data register, loaded in the address phase
    // Held until the next accepted read
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h00000000;
        end
        else if (ce && accept && !hwrite)
        begin
            hrdata <= next_rdata;
        end
    end

    // Settings to the rate decoder
    assign clk_cfg.pll_on = clock_ctrl[liu_cfg_pkg::CLK_PLL_BIT];
    assign clk_cfg.base_rate_sel = clock_ctrl[liu_cfg_pkg::CLK_BASE_BIT];
    assign clk_cfg.clock_multiple_sel = clock_ctrl[liu_cfg_pkg::CLK_MULT_LSB +: 2];

    // Master clock rate decoder
    // Its result lags the control register by one edge
    mclk_rate_decoder mclk_rate_decoder_i (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .cfg(clk_cfg)
    );

    // Clock settings and decoded rate to the pins
    assign pll_on = clk_cfg.pll_on;
    assign base_rate_sel = clk_cfg.base_rate_sel;
    assign clock_multiple_sel = clk_cfg.clock_multiple_sel;
    assign mclk_direct = clk_cfg.mclk_direct;
    assign mclk_khz = clk_cfg.mclk_khz;

    // Long haul enables straight from the banks
    assign long_haul_en = {haul_select_high_bank, haul_select_low_bank};

    // Per-channel receive controls; channel j sits in slot j/2, high half when j is odd
    // Outputs follow the registers one edge later, like the decoded rate
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rx_turns_ratio_ch <= 12'h000;
            rx_sense_level_ch <= 36'h000000000;
            rx_monitor_mode <= 12'h000;
            rx_monitor_gain_db <= 60'h000000000000000;
        end
        else if (ce)
        begin
            for (int j = 0; j < liu_cfg_pkg::SENSE_CH; j++)
            begin
                if (j[0])
                begin
                    // Higher channel of the pair: bit 7 and bits 6:4
                    rx_turns_ratio_ch[j] <= rx_sense[j/2][liu_cfg_pkg::TURNS_HI_BIT];
                    rx_sense_level_ch[j*3 +: 3] <= rx_sense[j/2][liu_cfg_pkg::LEVEL_HI_LSB +: 3];
                    rx_monitor_mode[j] <= is_monitor(rx_sense[j/2][liu_cfg_pkg::LEVEL_HI_LSB +: 3]);
                    rx_monitor_gain_db[j*5 +: 5] <= monitor_gain(rx_sense[j/2][liu_cfg_pkg::LEVEL_HI_LSB +: 3]);
                end
                else
                begin
                    // Lower channel of the pair: bit 3 and bits 2:0
                    rx_turns_ratio_ch[j] <= rx_sense[j/2][liu_cfg_pkg::TURNS_LO_BIT];
                    rx_sense_level_ch[j*3 +: 3] <= rx_sense[j/2][liu_cfg_pkg::LEVEL_LO_LSB +: 3];
                    rx_monitor_mode[j] <= is_monitor(rx_sense[j/2][liu_cfg_pkg::LEVEL_LO_LSB +: 3]);
                    rx_monitor_gain_db[j*5 +: 5] <= monitor_gain(rx_sense[j/2][liu_cfg_pkg::LEVEL_LO_LSB +: 3]);
                end
            end
        end
    end

endmodule

`default_nettype wire

//--- liu_cfg_bank_chk.sv
// Purpose: Concurrent checks on the configuration bank ports
// Assumes: One clock; read data and register updates follow the documented bus walk
// Notes: Bound to the bank from the testbench top file
`timescale 1ns/100ps
`default_nettype none
module liu_cfg_bank_chk (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic [15:0] long_haul_en,
    input wire logic [11:0] rx_turns_ratio_ch,
    input wire logic [35:0] rx_sense_level_ch,
    input wire logic [11:0] rx_monitor_mode,
    input wire logic [59:0] rx_monitor_gain_db,
    input wire logic pll_on,
    input wire logic base_rate_sel,
    input wire logic [1:0] clock_multiple_sel,
    input wire logic mclk_direct,
    input wire logic [15:0] mclk_khz
);
    // Address phase the bank accepts
    logic take;
    // Low byte of write data
    logic [7:0] wbyte;
    assign take = hsel && hready && htrans[1] && ce;
    assign wbyte = hwdata[7:0];

    // Expected master clock in kHz with the loop on
    function automatic logic [15:0] rate_of(input logic base, input logic [1:0] mult);
        rate_of = (base ? 16'h0608 : 16'h0800) << mult;
    endfunction

    // Expected gains above monitor flags, per channel
    function automatic logic [71:0] mon_of(input logic [35:0] s);
        for (int i = 0; i < 12; i++)
        begin
            mon_of[i] = s[3*i+2] && (s[3*i+:2] != 2'h3);
            mon_of[12+5*i+:5] = !mon_of[i] ? 5'h00 : (s[3*i+:2] == 2'h0) ? 5'h0e
                : (s[3*i+:2] == 2'h1) ? 5'h14 : 5'h1a;
        end
    endfunction

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    chk_haul_low: assert property (
        (take && hwrite && haddr == 8'h1c) ##1 ce |=> long_haul_en[7:0] == $past(wbyte))
        else $error("haul bank missed write data");
    chk_sense_low: assert property (
        (take && hwrite && haddr == 8'h20) ##1 ce |=> ##1 {rx_turns_ratio_ch[1], rx_sense_level_ch[5:3],
        rx_turns_ratio_ch[0], rx_sense_level_ch[2:0]} == $past(wbyte, 2))
        else $error("sense fields misplaced");
    chk_read_back: assert property (
        (take && !hwrite && haddr == 8'h1c) |=> hrdata == {24'h0, long_haul_en[7:0]})
        else $error("read data differs from register");
    chk_unmapped_read: assert property (
        (take && !hwrite && !(haddr[7:2] inside {6'h07, 6'h08, 6'h09, 6'h0a, 6'h27, 6'h28, 6'h29, 6'h30, 6'h31}))
        |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    chk_direct_follow: assert property (ce |=> mclk_direct == !$past(pll_on))
        else $error("direct clock flag wrong");
    chk_direct_khz: assert property (mclk_direct |-> mclk_khz == 16'h0)
        else $error("rate shown while loop off");
    chk_rate_pll: assert property (
        (ce && pll_on) |=> mclk_khz == rate_of($past(base_rate_sel), $past(clock_multiple_sel)))
        else $error("master clock rate wrong");
    chk_monitor_gain: assert property (
        {rx_monitor_gain_db, rx_monitor_mode} == mon_of(rx_sense_level_ch))
        else $error("monitor gain wrong");
endmodule
`default_nettype wire

//--- liu_cfg_bank_tb_top.sv
// Purpose: Self-checking bench for the configuration bank
// Assumes: Single slave, hready taken from hreadyout
// Notes: A shadow copy of the registers gives every expectation
`timescale 1ns/100ps
`default_nettype none
module liu_cfg_bank_tb_top;
    logic hclk, hresetn, ce, hsel, hwrite, hready, hreadyout, hresp, pll_on, base_rate_sel, mclk_direct;
    logic [7:0] haddr, k, c;
    logic [1:0] htrans, clock_multiple_sel;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, rd_data, e;
    logic [15:0] long_haul_en, mclk_khz;
    logic [11:0] rx_turns_ratio_ch, rx_monitor_mode;
    logic [35:0] rx_sense_level_ch;
    logic [59:0] rx_monitor_gain_db;
    logic [7:0] shadow [7]; // Last value written to each register
    logic [3:0] clk_cfg; // Last clock control setting
    int err_count, compares;
    // Byte addresses of the haul and sensitivity registers
    localparam logic [7:0] reg_addr [7] = '{8'h1c, 8'h20, 8'h24, 8'h28, 8'h9c, 8'ha0, 8'ha4};
    assign hready = hreadyout;
    liu_cfg_bank liu_cfg_bank_i (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .long_haul_en(long_haul_en),
        .rx_turns_ratio_ch(rx_turns_ratio_ch),
        .rx_sense_level_ch(rx_sense_level_ch),
        .rx_monitor_mode(rx_monitor_mode),
        .rx_monitor_gain_db(rx_monitor_gain_db),
        .pll_on(pll_on),
        .base_rate_sel(base_rate_sel),
        .clock_multiple_sel(clock_multiple_sel),
        .mclk_direct(mclk_direct),
        .mclk_khz(mclk_khz)
    );

    // Expected turns and sensitivity for channels 1-6 and 9-12
    function automatic logic [39:0] exp_rx();
        logic [7:0] r;
        for (int p = 0; p < 5; p++)
        begin
            r = shadow[p < 3 ? p + 1 : p + 2];
            exp_rx[2*p+:2] = {r[7], r[3]};
            exp_rx[10+6*p+:6] = {r[6:4], r[2:0]};
        end
    endfunction
    // Expected gain in dB and monitor flag for one sensitivity code
    function automatic logic [5:0] exp_mon(input logic [2:0] code);
        case (code)
            3'h4: exp_mon = {5'h0e, 1'h1};
            3'h5: exp_mon = {5'h14, 1'h1};
            3'h6: exp_mon = {5'h1a, 1'h1};
            default: exp_mon = 6'h00;
        endcase
    endfunction
    // Expected status: rate when the loop is on, direct flag otherwise
    function automatic logic [31:0] exp_status(input logic [3:0] m);
        exp_status = m[0] ? {16'h0, (m[1] ? 16'h0608 : 16'h0800) << m[3:2]} : 32'h0001_0000;
    endfunction
    // Counted comparison
    task automatic cmp(input string what, input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One single transfer; read data lands in rd_data
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd_data = hrdata;
    endtask
    // Read back every register except clock control and compare all outputs
    task automatic check_all();
        logic [39:0] rx;
        logic [35:0] lv;
        logic [5:0] m;
        for (int i = 0; i < 7; i++)
        begin
            xfer(1'b0, reg_addr[i], 32'h0);
            cmp("reg", 64'(rd_data), 64'(shadow[i]));
        end
        e = exp_status(clk_cfg);
        xfer(1'b0, 8'hc4, 32'h0);
        cmp("status", 64'(rd_data), 64'(e));
        cmp("ctrl", 64'({clock_multiple_sel, base_rate_sel, pll_on}), 64'(clk_cfg));
        cmp("rate", 64'({mclk_direct, mclk_khz}), 64'(e[16:0]));
        cmp("haul", 64'(long_haul_en), 64'({shadow[4], shadow[0]}));
        rx = exp_rx();
        lv = {6'h00, rx[39:10]};
        cmp("rx", 64'({rx_sense_level_ch, rx_turns_ratio_ch}), 64'({lv, 2'h0, rx[9:0]}));
        for (int ch = 0; ch < 12; ch++)
        begin
            m = exp_mon(lv[3*ch+:3]);
            cmp("mon", 64'({rx_monitor_gain_db[5*ch+:5], rx_monitor_mode[ch]}), 64'(m));
        end
        cmp("response", 64'({hreadyout, hresp}), 64'h2);
    endtask
    // Verdict and end of run
    task automatic test_done();
        $display("Comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Clock at 50 MHz
    initial
    begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    // Cuts a hang short
    initial
    begin
        repeat (5000) @(posedge hclk);
        err_count++;
        test_done();
    end
    // Main sequence
    initial
    begin
        hresetn = 1'b0;
        ce = 1'b1;
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        err_count = 0;
        compares = 0;
        shadow = '{default: 8'h00};
        clk_cfg = 4'h0;
        void'($urandom(1592));
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check_all();
        // Every sensitivity code first, then random registers and data
        for (int i = 0; i < 40; i++)
        begin
            c = 8'(i);
            k = (i < 8) ? 8'h01 : 8'($urandom % 7);
            shadow[k] = (i < 8) ? {c[0], c[2:0], ~c[0], c[2:0]} : 8'($urandom);
            xfer(1'b1, reg_addr[k], {24'($urandom), shadow[k]});
            check_all();
        end
        // Status is read only, unmapped places read zero
        xfer(1'b1, 8'hc4, 32'hffff_ffff);
        for (int i = 0; i < 2; i++)
        begin
            xfer(1'b1, i ? 8'hfc : 8'h2c, 32'hffff_ffff);
            xfer(1'b0, i ? 8'hfc : 8'h2c, 32'h0);
            cmp("unmapped", 64'(rd_data), 64'h0);
        end
        // Every loop, base and multiple setting
        for (int m = 0; m < 16; m++)
        begin
            clk_cfg = 4'(m);
            xfer(1'b1, 8'hc0, {28'h0, clk_cfg});
            check_all();
        end
        // Clock enable low refuses a write
        ce <= 1'b0;
        xfer(1'b1, reg_addr[0], 32'h0000_00a5);
        ce <= 1'b1;
        check_all();
        // Long haul on channel 1 with its 1:1 transformer flagged, as software is told to
        shadow[0] = 8'h01;
        shadow[1][3] = 1'b1;
        xfer(1'b1, reg_addr[0], {24'h0, shadow[0]});
        xfer(1'b1, reg_addr[1], {24'h0, shadow[1]});
        check_all();
        // Second reset in mid-run clears everything
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        shadow = '{default: 8'h00};
        clk_cfg = 4'h0;
        @(posedge hclk);
        check_all();
        test_done();
    end
endmodule

bind liu_cfg_bank liu_cfg_bank_chk liu_cfg_bank_chk_i (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hwdata(hwdata),
    .hready(hready),
    .hrdata(hrdata),
    .long_haul_en(long_haul_en),
    .rx_turns_ratio_ch(rx_turns_ratio_ch),
    .rx_sense_level_ch(rx_sense_level_ch),
    .rx_monitor_mode(rx_monitor_mode),
    .rx_monitor_gain_db(rx_monitor_gain_db),
    .pll_on(pll_on),
    .base_rate_sel(base_rate_sel),
    .clock_multiple_sel(clock_multiple_sel),
    .mclk_direct(mclk_direct),
    .mclk_khz(mclk_khz)
);
`default_nettype wire

//--- liu_cfg_pkg.sv
// Purpose: Shared constants for the line interface clock and receive sensitivity register bank
// Assumes: Register indices are word indices; byte address is four times the index
// Notes: Widths are fixed; no parameters of the top module

`default_nettype none

package liu_cfg_pkg;

    // Register indices (byte address = index * 4)
    localparam logic [5:0] IDX_HAUL_LO = 6'h07;
    localparam logic [5:0] IDX_SENSE_CH1_CH2 = 6'h08;
    localparam logic [5:0] IDX_SENSE_CH3_CH4 = 6'h09;
    localparam logic [5:0] IDX_SENSE_CH5_CH6 = 6'h0a;
    localparam logic [5:0] IDX_HAUL_HI = 6'h27;
    localparam logic [5:0] IDX_SENSE_CH9_CH10 = 6'h28;
    localparam logic [5:0] IDX_SENSE_CH11_CH12 = 6'h29;
    localparam logic [5:0] IDX_CLOCK_CTRL = 6'h30;
    localparam logic [5:0] IDX_CLOCK_STATUS = 6'h31;

    // Reset value of every writable register
    localparam logic [7:0] REG_RESET = 8'h00;

    // Receive sensitivity register field layout
    localparam int TURNS_HI_BIT = 7;
    localparam int LEVEL_HI_LSB = 4;
    localparam int TURNS_LO_BIT = 3;
    localparam int LEVEL_LO_LSB = 0;

    // Clock control register field layout
    localparam int CLK_PLL_BIT = 0;
    localparam int CLK_BASE_BIT = 1;
    localparam int CLK_MULT_LSB = 2;

    // Clock status register field layout
    localparam int STATUS_DIRECT_BIT = 16;

    // Base master clock rates in kHz
    localparam logic [15:0] MCLK_T1_KHZ = 16'h0608;
    localparam logic [15:0] MCLK_E1_KHZ = 16'h0800;

    // Sensitivity codes and monitor gains in dB
    localparam logic [2:0] SENSE_MON_14DB = 3'h4;
    localparam logic [2:0] SENSE_MON_20DB = 3'h5;
    localparam logic [2:0] SENSE_MON_26DB = 3'h6;
    localparam logic [4:0] GAIN_14DB = 5'h0e;
    localparam logic [4:0] GAIN_20DB = 5'h14;
    localparam logic [4:0] GAIN_26DB = 5'h1a;
    localparam logic [4:0] GAIN_NONE = 5'h00;

    // Channel and sensitivity register counts
    localparam int HAUL_CH = 16;
    localparam int SENSE_CH = 12;
    localparam int SENSE_REGS = 6;

endpackage

`default_nettype wire

//--- mclk_rate_decoder.sv
// Purpose: Decodes the master clock settings into the expected input rate
// Assumes: Settings are stable register outputs
// Notes: Result is registered, one cycle behind the settings

`timescale 1ns/100ps
`default_nettype none

module mclk_rate_decoder (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    clk_cfg_if.dec cfg
);

    // Registered decode of the clock settings
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cfg.mclk_khz <= 16'h0000;
            cfg.mclk_direct <= 1'b1;
        end
        else if (ce)
        begin
            if (!cfg.pll_on)
            begin
                // Loop off: clock taken as is, multiple and base are ignored
                cfg.mclk_direct <= 1'b1;
                cfg.mclk_khz <= 16'h0000;
            end
            else if (cfg.base_rate_sel)
            begin
                // 1.544 family: 1x, 2x, 4x, 8x
                cfg.mclk_direct <= 1'b0;
                cfg.mclk_khz <= liu_cfg_pkg::MCLK_T1_KHZ << cfg.clock_multiple_sel;
            end
            else
            begin
                // 2.048 family: 1x, 2x, 4x, 8x
                cfg.mclk_direct <= 1'b0;
                cfg.mclk_khz <= liu_cfg_pkg::MCLK_E1_KHZ << cfg.clock_multiple_sel;
            end
        end
    end

endmodule

`default_nettype wire
